// file: pkg/scit_regs.vh
// register map, field positions, reset values and counts of the spi crc/irq/tx block
`ifndef SCIT_REGS_VH
`define SCIT_REGS_VH

`define SCIT_ADDR_W 12
`define SCIT_DATA_W 8

`define SCIT_ADDR_CRC_LO 12'h826
`define SCIT_ADDR_CRC_HI 12'h827
`define SCIT_ADDR_STAT_LO 12'h828
`define SCIT_ADDR_STAT_HI 12'h829
`define SCIT_ADDR_CLREN_LO 12'h82A
`define SCIT_ADDR_CLREN_HI 12'h82B
`define SCIT_ADDR_IEN_LO 12'h82C
`define SCIT_ADDR_IEN_HI 12'h82D
`define SCIT_ADDR_REQ_LO 12'h82E
`define SCIT_ADDR_REQ_HI 12'h82F
`define SCIT_ADDR_TXD_LO 12'h830
`define SCIT_ADDR_TXD_HI 12'h831

`define SCIT_BIT_TX_END 3
`define SCIT_BIT_RX_END 2
`define SCIT_BIT_TX_BUF 1
`define SCIT_BIT_RX_BUF 0
`define SCIT_NUM_IRQ 4

`define SCIT_RST_CRC 16'h0000
`define SCIT_RST_TXD 16'h0000
`define SCIT_RST_IRQ 4'h0
`define SCIT_RST_BYTE 8'h00

`define SCIT_FRAME_BITS 16
`define SCIT_SYNC_STAGES 2

`endif

// file: hw/scit_sync.v
// two-stage synchroniser with edge detection for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module scit_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  input wire mclk,
  input wire rst_n,
  input wire async_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // first stage feeds only the second stage
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= RESET_LEVEL;
      sync_reg <= RESET_LEVEL;
      last_reg <= RESET_LEVEL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;

endmodule // scit_sync

`default_nettype wire

// file: hw/scit_core.v
// register side of the spi controller: crc result, interrupt flags, transmit data
`timescale 1ns/10ps
`default_nettype none

`include "scit_regs.vh"

module scit_core #(
  parameter FRAME_BITS = `SCIT_FRAME_BITS
) (
  input wire mclk,
  input wire rst_n,
  input wire [`SCIT_ADDR_W-1:0] addr,
  input wire [`SCIT_DATA_W-1:0] wdata,
  input wire wr,
  input wire rd,
  output wire [`SCIT_DATA_W-1:0] rdata,
  input wire [15:0] crc_result_bits,
  input wire crc_load,
  input wire receive_end,
  input wire rx_buffer_event,
  input wire link_clk,
  output wire [15:0] transmit_data,
  output wire tx_active,
  output wire tx_start,
  output wire irq
);

  localparam ST_IDLE = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_DONE = 2'b10;
  // counter is six bits wide, enough for frames of up to 64 bits
  localparam [5:0] FRAME_LAST = FRAME_BITS - 1;

  reg [15:0] crc_reg;
  reg [15:0] crc_next;
  reg [15:0] txd_reg;
  reg [15:0] txd_next;
  reg [`SCIT_NUM_IRQ-1:0] status_reg;
  reg [`SCIT_NUM_IRQ-1:0] status_next;
  reg [`SCIT_NUM_IRQ-1:0] clren_reg;
  reg [`SCIT_NUM_IRQ-1:0] clren_next;
  reg [`SCIT_NUM_IRQ-1:0] ien_reg;
  reg [`SCIT_NUM_IRQ-1:0] ien_next;
  reg [`SCIT_DATA_W-1:0] rdata_reg;
  reg [`SCIT_DATA_W-1:0] rdata_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [5:0] bit_cnt_reg;
  reg [5:0] bit_cnt_next;
  reg pend_reg;
  reg pend_next;
  reg start_reg;
  reg start_next;

  wire link_rise;
  wire [`SCIT_NUM_IRQ-1:0] request;
  wire [`SCIT_NUM_IRQ-1:0] set_evt;
  wire [`SCIT_NUM_IRQ-1:0] clr_req;
  wire wr_txd_hi;
  wire wr_stat;
  wire frame_end;

  // link clock is only sampled; its rising edges pace the transmit bit count
  scit_sync #(
    .RESET_LEVEL(1'b0)
  ) u_link_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(link_clk),
    .level(),
    .rise(link_rise),
    .fall()
  );

  // address decodes shared by the clear path and the sequencer
  assign wr_txd_hi = wr && (addr == `SCIT_ADDR_TXD_HI);
  assign wr_stat = wr && (addr == `SCIT_ADDR_STAT_LO);
  assign frame_end = (state_reg == ST_SHIFT) && link_rise && (bit_cnt_reg == FRAME_LAST);

  // hardware events that set the flags
  assign set_evt[`SCIT_BIT_TX_END] = frame_end;
  assign set_evt[`SCIT_BIT_RX_END] = receive_end;
  assign set_evt[`SCIT_BIT_TX_BUF] = start_reg;
  assign set_evt[`SCIT_BIT_RX_BUF] = rx_buffer_event;

  // clear needs the written one and the enable bit
  assign clr_req = wr_stat ?
    (wdata[`SCIT_NUM_IRQ-1:0] & clren_reg) : `SCIT_RST_IRQ;

  assign request = status_reg & ien_reg;

  // a set in the same cycle as its clear wins, so no event is lost
  always @* begin
    status_next = (status_reg & ~clr_req) | set_evt;
  end

  // register writes and crc result load
  always @* begin
    crc_next = crc_reg;
    txd_next = txd_reg;
    clren_next = clren_reg;
    ien_next = ien_reg;
    if (crc_load) begin
      crc_next = crc_result_bits;
    end
    if (wr) begin
      case (addr)
        `SCIT_ADDR_CLREN_LO: begin
          clren_next = wdata[`SCIT_NUM_IRQ-1:0];
        end
        `SCIT_ADDR_IEN_LO: begin
          ien_next = wdata[`SCIT_NUM_IRQ-1:0];
        end
        `SCIT_ADDR_TXD_LO: begin
          txd_next[7:0] = wdata;
        end
        `SCIT_ADDR_TXD_HI: begin
          txd_next[15:8] = wdata;
        end
        default: begin
          txd_next = txd_reg;
        end
      endcase
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always @* begin
    rdata_next = `SCIT_RST_BYTE;
    if (rd) begin
      case (addr)
        `SCIT_ADDR_CRC_LO: begin
          rdata_next = crc_reg[7:0];
        end
        `SCIT_ADDR_CRC_HI: begin
          rdata_next = crc_reg[15:8];
        end
        `SCIT_ADDR_STAT_LO: begin
          // four flags in the low nibble
          rdata_next = {4'h0, status_reg};
        end
        `SCIT_ADDR_CLREN_LO: begin
          rdata_next = {4'h0, clren_reg};
        end
        `SCIT_ADDR_IEN_LO: begin
          rdata_next = {4'h0, ien_reg};
        end
        `SCIT_ADDR_REQ_LO: begin
          rdata_next = {4'h0, request};
        end
        default: begin
          // transmit data is write-only, unmapped and upper bytes other than the crc high byte read zero
          rdata_next = `SCIT_RST_BYTE;
        end
      endcase
    end
  end

  // transmit sequencer: high byte write completes the word and queues a frame
  always @* begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    pend_next = pend_reg | wr_txd_hi;
    start_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (pend_reg) begin
          pend_next = wr_txd_hi;
          start_next = 1'b1;
          bit_cnt_next = 6'h00;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // counts synchronised rising edges only
        if (link_rise) begin
          bit_cnt_next = bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == FRAME_LAST) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // one idle cycle so the next word never overlaps the end flag
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // crc value held until the engine loads a new one
  always @(posedge mclk) begin
    if (!rst_n) begin
      crc_reg <= `SCIT_RST_CRC;
    end else begin
      crc_reg <= crc_next;
    end
  end

  // transmit word; bytes land independently
  always @(posedge mclk) begin
    if (!rst_n) begin
      txd_reg <= `SCIT_RST_TXD;
    end else begin
      txd_reg <= txd_next;
    end
  end

  // sticky flags
  always @(posedge mclk) begin
    if (!rst_n) begin
      status_reg <= `SCIT_RST_IRQ;
    end else begin
      status_reg <= status_next;
    end
  end

  // clear enables; zero after reset so stray writes cannot clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      clren_reg <= `SCIT_RST_IRQ;
    end else begin
      clren_reg <= clren_next;
    end
  end

  // interrupt enables
  always @(posedge mclk) begin
    if (!rst_n) begin
      ien_reg <= `SCIT_RST_IRQ;
    end else begin
      ien_reg <= ien_next;
    end
  end

  // read data register, zero outside the answer cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg <= `SCIT_RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // sequencer state
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bit counter of the running frame
  always @(posedge mclk) begin
    if (!rst_n) begin
      bit_cnt_reg <= 6'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // one pending word only; a second write overwrites the queued word
  always @(posedge mclk) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // registered start pulse keeps the output glitch free
  always @(posedge mclk) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
    end
  end

  assign rdata = rdata_reg;
  // word is not frozen during a frame; software waits for tx end
  assign transmit_data = txd_reg;
  assign tx_active = (state_reg == ST_SHIFT);
  assign tx_start = start_reg;
  // level output with no stretching
  assign irq = |request;

endmodule // scit_core

`default_nettype wire

// file: bench/scit_link_model.sv
// far-side link partner: runs the link clock only while a frame shifts
`timescale 1ns/10ps
`default_nettype none
module scit_link_model (
  input wire logic tx_active,
  output logic link_clk
);
  initial begin
    link_clk = 1'b0;
    forever begin
      wait (tx_active);
      // random start keeps the link phase off the system clock grid
      #($urandom_range(39, 1));
      while (tx_active) begin
        #160 link_clk = 1'b1;
        #160 link_clk = 1'b0;
      end
    end
  end
endmodule // scit_link_model
`default_nettype wire

// file: bench/scit_core_asserts.sv
// checker of the register bus, transmit word and interrupt output
`timescale 1ns/10ps
`default_nettype none
module scit_core_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [15:0] transmit_data,
  input wire logic tx_active,
  input wire logic tx_start,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  txd_read_a: assert property (rd && addr[11:1] == 11'h418 |=> rdata == 8'h00)
    else $error("transmit word readable");
  txd_lo_a: assert property (wr && addr == 12'h830 |=> transmit_data[7:0] == $past(wdata))
    else $error("low byte not loaded");
  txd_hi_a: assert property (wr && addr == 12'h831 |=> transmit_data[15:8] == $past(wdata))
    else $error("high byte not loaded");
  txd_hold_a: assert property (!$past(wr) |-> $stable(transmit_data))
    else $error("transmit word moved");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr)) else $error("irq fell alone");
  tx_go_a: assert property (wr && addr == 12'h831 && !tx_active |-> ##[1:3] tx_start)
    else $error("frame not started");
  go_pulse_a: assert property (tx_start |-> tx_active ##1 !tx_start)
    else $error("start pulse wrong");
  frame_len_a: assert property ($rose(tx_active) |-> tx_active [*8])
    else $error("frame too short");
  cover property (tx_start);
  cover property ($fell(irq));
  cover property (rd && addr == 12'h826);
endmodule // scit_core_asserts
bind scit_core scit_core_asserts scit_core_asserts_inst (.mclk(mclk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .transmit_data(transmit_data), .tx_active(tx_active), .tx_start(tx_start), .irq(irq));
`default_nettype wire

// file: bench/scit_core_tb.sv
// self-checking bench of the crc, interrupt and transmit registers
`timescale 1ns/10ps
`default_nettype none
module scit_core_tb;
  logic mclk, rst_n, wr, rd, crc_load, receive_end, rx_buffer_event, link_clk, rd_d;
  logic tx_active, tx_start, irq;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [15:0] crc_bits, txd, v;
  logic [7:0] q[$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  scit_core scit_core_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .crc_result_bits(crc_bits), .crc_load(crc_load),
    .receive_end(receive_end), .rx_buffer_event(rx_buffer_event), .link_clk(link_clk),
    .transmit_data(txd), .tx_active(tx_active), .tx_start(tx_start), .irq(irq));
  scit_link_model scit_link_model_inst (.tx_active(tx_active), .link_clk(link_clk));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // a read notes its expected byte; d doubles as that byte
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) q.push_back(d);
    @(posedge mclk);
  endtask
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic irqc(input logic e);
    idle(0);
    @(negedge mclk);
    chk("irq", {15'h0000, e}, {15'h0000, irq});
    @(posedge mclk);
  endtask
  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) if (rd_d) chk("rdata", {8'h00, q.pop_front()}, {8'h00, rdata});
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rst_n, wr, rd, crc_load, receive_end, rx_buffer_event} = 6'h00;
    addr = 12'h000;
    wdata = 8'h00;
    crc_bits = 16'h0000;
    void'($urandom(60316));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) bus(1'b0, 12'h826 + 12'(i), 8'h00);
    idle(2);
    $display("reset values done");
    v = 16'($urandom);
    crc_bits <= v;
    crc_load <= 1'b1;
    bus(1'b1, 12'h826, ~v[7:0]);
    crc_load <= 1'b0;
    bus(1'b0, 12'h826, v[7:0]);
    bus(1'b0, 12'h827, v[15:8]);
    idle(2);
    $display("crc done");
    bus(1'b1, 12'h82C, 8'h0F);
    bus(1'b0, 12'h82C, 8'h0F);
    receive_end <= 1'b1;
    rx_buffer_event <= 1'b1;
    idle(1);
    receive_end <= 1'b0;
    rx_buffer_event <= 1'b0;
    irqc(1'b1);
    bus(1'b0, 12'h828, 8'h05);
    bus(1'b0, 12'h82E, 8'h05);
    // clear-enable still zero, so this clear must not act
    bus(1'b1, 12'h828, 8'h0F);
    bus(1'b0, 12'h828, 8'h05);
    bus(1'b1, 12'h82A, 8'h04);
    bus(1'b1, 12'h828, 8'h0F);
    bus(1'b0, 12'h828, 8'h01);
    bus(1'b0, 12'h82A, 8'h04);
    bus(1'b1, 12'h82A, 8'h0F);
    bus(1'b1, 12'h828, 8'h00);
    bus(1'b0, 12'h828, 8'h01);
    bus(1'b1, 12'h82C, 8'h0E);
    bus(1'b0, 12'h82E, 8'h00);
    irqc(1'b0);
    bus(1'b1, 12'h82C, 8'h0F);
    irqc(1'b1);
    bus(1'b1, 12'h828, 8'h01);
    irqc(1'b0);
    $display("interrupts done");
    v = 16'($urandom);
    bus(1'b1, 12'h830, v[7:0]);
    bus(1'b1, 12'h831, v[15:8]);
    idle(1);
    chk("txd", v, txd);
    for (int i = 0; i < 20 && tx_active !== 1'b1; i++) @(posedge mclk);
    for (int i = 0; i < 400 && tx_active !== 1'b0; i++) @(posedge mclk);
    idle(3);
    bus(1'b0, 12'h828, 8'h0A);
    bus(1'b0, 12'h82E, 8'h0A);
    irqc(1'b1);
    $display("transmit done");
    conclude();
  end
endmodule // scit_core_tb
`default_nettype wire
